// [dv/far_side_model.sv]
`timescale 1ns/1ps
// stands in for the tick oscillator, trigger source and external timer
module far_side_model #(
  parameter int TICK_CYC = 200
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bench controls
  input wire logic trig_en,
  input wire logic ext_en,
  input wire logic [15:0] ext_dly,
  // sequencer output watched
  input wire logic integration_active,
  // stimulus to the sequencer
  output logic unit_integration_tick,
  output logic capture_trigger,
  output logic ext_integration_end
);
  int ph = 0;
  int age = 0;
  initial begin
    unit_integration_tick = 1'b0;
    capture_trigger = 1'b0;
    ext_integration_end = 1'b0;
  end
  // tick free-runs even through reset, as a real oscillator would
  always @(posedge clk) begin
    ph <= (ph >= TICK_CYC - 1) ? 0 : ph + 1;
    unit_integration_tick <= (ph < TICK_CYC / 2);
    capture_trigger <= trig_en && (ph >= TICK_CYC / 2) && (ph < TICK_CYC / 2 + 4);
    age <= integration_active ? age + 1 : 0;
    // timer end rises once per integration, falls when integration stops
    ext_integration_end <= ext_en && integration_active && (age >= int'(ext_dly));
  end
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import ccd_seq_pkg::*;
  localparam int TICK = 200;
  localparam logic [9:0] HIGHS = 10'h00b;
  // clock, reset, jumpers, partner controls
  logic clk, reset = 1'b1, trig_j = 1'b0, bin_j = 1'b0, ext_j = 1'b0, amp_j = 1'b0;
  logic trig_en = 1'b0, ext_en = 1'b0, tick, trig, ext_end;
  logic [15:0] ext_dly = 16'h0100;
  // register bus
  logic [3:0] address = 4'h0, byteenable = 4'h0;
  logic read = 1'b0, write = 1'b0, waitrequest;
  logic [31:0] writedata = 32'h0, readdata, rd, rng = 32'h0a1a;
  // ccd and grabber side
  logic va, vb, ha, hb, dr, clamp, samp, amp_low, integ, fs, ls, ps;
  int n_mismatch = 0, checked = 0, cyc = 0, tick_age = 0, int_age = 99, va_gap = 99, t_fall = -1;
  int cnt[10] = '{default: 0};
  int base[10];
  logic [10:0] prev = 11'h000;
  wire logic [10:0] v = {tick, ha, samp, clamp, dr, ps, ls, vb, va, amp_low, integ};
  wire logic [11:0] outs = {va, vb, ha, hb, dr, clamp, samp, amp_low, integ, fs, ls, ps};

  far_side_model #(.TICK_CYC(TICK)) far_u (.clk(clk), .reset(reset), .trig_en(trig_en), .ext_en(ext_en),
    .ext_dly(ext_dly), .integration_active(integ), .unit_integration_tick(tick), .capture_trigger(trig),
    .ext_integration_end(ext_end));
  ccd_frame_timing_sequencer #(.NUM_ROWS(12'h004), .NUM_COLS(12'h004), .FLUSH_LINES(12'h002)) dut_u (
    .clk(clk), .reset(reset), .capture_mode_jumper(trig_j), .binning_jumper(bin_j),
    .integration_source_jumper(ext_j), .amp_disable_jumper(amp_j), .unit_integration_tick(tick),
    .capture_trigger(trig), .ext_integration_end(ext_end), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .vertical_phase_a(va), .vertical_phase_b(vb), .horizontal_phase_a(ha), .horizontal_phase_b(hb),
    .diffusion_reset_clock(dr), .clamp_clock(clamp), .sample_clock(samp), .reduced_amp_supply(amp_low),
    .integration_active(integ), .grabber_frame_sync(fs), .grabber_line_sync(ls), .grabber_pixel_strobe(ps));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // event monitor: non-blocking so task reads see settled pre-edge counts
  always @(posedge clk) begin
    prev <= v;
    cyc <= cyc + 1;
    tick_age <= (v[10] && !prev[10]) ? 0 : tick_age + 1;
    for (int i = 0; i < 10; i++) begin
      if (v[i] === 1'b1 && (HIGHS[i] || prev[i] !== 1'b1)) cnt[i] <= cnt[i] + 1;
    end
    if (v[0] === 1'b1 && prev[0] !== 1'b1) int_age <= tick_age;
    if (v[0] !== 1'b1 && prev[0] === 1'b1) begin
      t_fall <= cyc;
      va_gap <= -1;
    end
    // only the first vertical pulse after integration measures the gap
    if (v[2] === 1'b1 && prev[2] !== 1'b1 && va_gap < 0) va_gap <= cyc - t_fall;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // unit ticks for the low end of the duration table
  function automatic int exp_ticks(input int s);
    return (s <= 10) ? s : (s - 9) * 10;
  endfunction

  // per-frame event counts for a 4x4 array with two flush lines
  function automatic int exp_cnt(input int i, input logic b, input logic t);
    int lines, vp;
    lines = b ? 2 : 4;
    vp = 4 + (t ? 2 : 0);
    case (i)
      2: return vp;
      3: return vp * V_PULSE_CYC;
      4: return lines;
      9: return lines * 4;
      default: return lines * (b ? 2 : 4);
    endcase
  endfunction

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one avalon access; request held until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    chk("bus latency", n, 2);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task wait_fs(input logic want);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (fs !== want && n < 12000);
    chk("frame sync wait", fs, want);
  endtask

  // discard the frame in flight, then count one whole frame
  task frame();
    wait_fs(1'b1);
    wait_fs(1'b0);
    base = cnt;
    wait_fs(1'b1);
    wait_fs(1'b0);
  endtask

  task run_mode(input logic t, input logic b, input logic e, input logic a, input logic x, input int sel);
    int lo, hi, got;
    trig_j <= t;
    bin_j <= b;
    ext_j <= e;
    amp_j <= a;
    trig_en <= t;
    ext_en <= x;
    bus(1'b1, REG_INT_SEL, 32'(sel), 4'h1);
    frame();
    for (int i = 2; i < 10; i++) begin
      chk("event count", cnt[i] - base[i], exp_cnt(i, b, t));
    end
    got = cnt[0] - base[0];
    lo = e ? int'(ext_dly) + 2 : (sel == 0 ? 1 : exp_ticks(sel) * TICK - 4);
    hi = e ? int'(ext_dly) + 8 : (sel == 0 ? 1 : exp_ticks(sel) * TICK + 4);
    chk("integration length", (got >= lo) && (got <= hi), 1);
    chk("reduced supply cycles", cnt[1] - base[1], a ? got : 0);
    chk("tick alignment", int_age <= 6, 1);
    chk("row start gap", va_gap, 1);
    bus(1'b0, REG_STATUS, 32'h0, 4'hf);
    chk("latched modes", rd[7:4], {a, e, b, t});
  endtask

  task conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog sized well above the expected run of about 30k cycles
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("outputs after reset", outs, 0);
    chk("waitrequest after reset", waitrequest, 1'b1);
    bus(1'b0, REG_INT_SEL, 32'h0, 4'hf);
    chk("select reset value", rd, 32'(INT_SEL_RST));
    rng = xs(rng);
    bus(1'b1, REG_INT_SEL, rng, 4'hf);
    bus(1'b1, REG_INT_SEL, ~rng, 4'he);
    bus(1'b1, 4'h8, ~rng, 4'hf);
    bus(1'b0, REG_INT_SEL, 32'h0, 4'hf);
    chk("select field", rd, {27'h0, rng[4:0]});
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk("unmapped read", rd, 32'h0);
    run_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 0);
    run_mode(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 10);
    rng = xs(rng);
    run_mode(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2 + int'(rng % 9));
    // external end pulses here must be ignored in internal mode
    run_mode(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 11);
    rng = xs(rng);
    ext_dly <= 16'h0064 + {8'h00, rng[7:0]};
    run_mode(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 0);
    // triggered mode with no trigger must sit idle; the jumper moves during
    // readout so a sequencer parked in initialize cannot be stranded
    wait_fs(1'b1);
    trig_j <= 1'b1;
    trig_en <= 1'b0;
    wait_fs(1'b0);
    base = cnt;
    repeat (3 * TICK) @(posedge clk);
    chk("idle without trigger", cnt[0] - base[0], 0);
    run_mode(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3);
    run_mode(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 0);
    // second reset in mid-frame
    wait_fs(1'b1);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    chk("outputs in reset", outs, 0);
    reset <= 1'b0;
    bus(1'b0, REG_INT_SEL, 32'h0, 4'hf);
    chk("select after reset", rd, 32'(INT_SEL_RST));
    conclude();
  end
endmodule

// [inc/ccd_seq_pkg.sv]
package ccd_seq_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    ST_CLEAR = 3'b000,
    ST_INIT = 3'b001,
    ST_FLUSH = 3'b010,
    ST_INTEG = 3'b011,
    ST_VXFER = 3'b100,
    ST_HXFER = 3'b101,
    ST_LCHECK = 3'b110
  } seq_state_t;

  // system clock and vertical clock timing, fixed in logic
  localparam int CLK_MHZ = 20;
  localparam int V_PULSE_NS = 1000;
  localparam int THS_NS = 500;
  localparam int V_PULSE_CYC = (V_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int THS_CYC = (THS_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] V_A_END = 8'(V_PULSE_CYC);
  localparam logic [7:0] V_B_END = 8'(2 * V_PULSE_CYC);
  localparam logic [7:0] VT_LAST = 8'(2 * V_PULSE_CYC + THS_CYC - 1);

  // positions within one pixel, in sixteenths of a pixel
  localparam logic [3:0] PIX_LAST = 4'hf;
  localparam logic [3:0] H_SPLIT = 4'h8;
  localparam logic [3:0] CLAMP_ON = 4'h3;
  localparam logic [3:0] CLAMP_OFF = 4'h4;
  localparam logic [3:0] SAMP_ON = 4'hb;
  localparam logic [3:0] SAMP_OFF = 4'hc;
  localparam logic [3:0] STROBE_ON = 4'hc;
  localparam logic [3:0] STROBE_OFF = 4'hd;
  localparam logic [3:0] RST_ON = 4'he;
  localparam logic [3:0] RST_OFF = 4'hf;

  // register map (byte addresses) and reset values
  localparam logic [3:0] REG_INT_SEL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [4:0] INT_SEL_RST = 5'h00;

  // inclusive window on the pixel phase counter
  function automatic logic in_win(input logic [3:0] p, input logic [3:0] lo, input logic [3:0] hi);
    return (p >= lo) && (p <= hi);
  endfunction

  // integration time select to count of unit ticks (10 ms each)
  function automatic logic [12:0] int_ticks(input logic [4:0] sel);
    logic [12:0] t;
    t = 13'h0000;
    if (sel <= 5'h0a) begin
      t = {8'h00, sel};
    end else if (sel <= 5'h13) begin
      t = 13'(({8'h00, sel} - 13'h0009) * 13'h000a);
    end else if (sel <= 5'h1c) begin
      t = 13'(({8'h00, sel} - 13'h0012) * 13'h0064);
    end else if (sel == 5'h1d) begin
      t = 13'h015e;
    end else if (sel == 5'h1e) begin
      t = 13'h1388;
    end else begin
      t = 13'h1964;
    end
    return t;
  endfunction

endpackage

// [inc/seq_ctl_if.sv]
`timescale 1ns/1ps
interface seq_ctl_if;
  logic [4:0] int_sel;
  logic [2:0] state_code;
  logic [3:0] modes;
  logic [11:0] line;
  modport regs(output int_sel, input state_code, input modes, input line);
  modport core(input int_sel, output state_code, output modes, output line);
endinterface

// [src/avalon_regs.sv]
`timescale 1ns/1ps
module avalon_regs
  import ccd_seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // sequencer side
  seq_ctl_if.regs ctl
);
  logic [31:0] rd_mux;
  logic req;
  logic wr_take;

  // read decode, unmapped offsets read as zero
  assign req = read | write;
  assign wr_take = write & ~waitrequest & (address == REG_INT_SEL) & byteenable[0];
  assign rd_mux = (address == REG_INT_SEL) ? {27'h0, ctl.int_sel} :
                  (address == REG_STATUS) ? {4'h0, ctl.line, 8'h00, ctl.modes, 1'b0, ctl.state_code} :
                  32'h00000000;

  // one wait cycle per access, then waitrequest returns high
  always_ff @(posedge clk) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else begin
      waitrequest <= ~(req & waitrequest);
      if (read & waitrequest) begin
        readdata <= rd_mux;
      end
    end
  end

  // integration time select, writes to other offsets are dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl.int_sel <= INT_SEL_RST;
    end else if (wr_take) begin
      ctl.int_sel <= writedata[4:0];
    end
  end
endmodule

// [src/ccd_frame_timing_sequencer.sv]
`timescale 1ns/1ps
// Operation
// - amp jumper low keeps normal supply always
// - amp jumper high lowers supply during integration
// - reset clears counters, state, mode registers
// - free run; clear/setup resets counters each frame
// - initialize samples modes, continuous waits tick
// - flush only in triggered capture mode
// - flush toggles vertical clocks, then waits tick
// - integration output high throughout integrate
// - internal mode ends after selected tick count
// - external mode ends on end input rising
// - vertical counter times clocks and delay
// - binning shifts two rows per readout
// - vertical clock timing fixed, not programmable
// - pixel counter times shifting and grabber syncs
// - binning sums two pixels before sensing
// - binning gates reset, clamp, sample, strobe
// - line check counts rows, ends or repeats
// - triggered mode waits trigger per frame
// - capture and binning jumpers, low default
// - integration source jumper, low internal
// - select field picks one of 32 durations
module ccd_frame_timing_sequencer
  import ccd_seq_pkg::*;
#(
  parameter logic [11:0] NUM_ROWS = 12'h800,
  parameter logic [11:0] NUM_COLS = 12'h800,
  parameter logic [11:0] FLUSH_LINES = 12'h800
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // mode jumpers
  input wire logic capture_mode_jumper,
  input wire logic binning_jumper,
  input wire logic integration_source_jumper,
  input wire logic amp_disable_jumper,
  // timing and trigger inputs
  input wire logic unit_integration_tick,
  input wire logic capture_trigger,
  input wire logic ext_integration_end,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // ccd and converter clocks
  output logic vertical_phase_a,
  output logic vertical_phase_b,
  output logic horizontal_phase_a,
  output logic horizontal_phase_b,
  output logic diffusion_reset_clock,
  output logic clamp_clock,
  output logic sample_clock,
  output logic reduced_amp_supply,
  output logic integration_active,
  // framegrabber syncs
  output logic grabber_frame_sync,
  output logic grabber_line_sync,
  output logic grabber_pixel_strobe
);
  seq_ctl_if ctl ();

  seq_state_t state;
  seq_state_t next_state;
  logic [6:0] s_lvl;
  logic [6:0] s_rise;
  logic m_trig;
  logic m_bin;
  logic m_ext;
  logic m_amp;
  logic [7:0] vcnt;
  logic vrep;
  logic [11:0] flines;
  logic [3:0] pcnt;
  logic [11:0] col;
  logic [11:0] line;
  logic [12:0] itick;

  // every jumper, tick, trigger and end input passes the synchroniser first
  edge_sync #(.W(7)) u_sync (
    .clk(clk),
    .reset(reset),
    .d({amp_disable_jumper, integration_source_jumper, binning_jumper, capture_mode_jumper,
        ext_integration_end, capture_trigger, unit_integration_tick}),
    .lvl(s_lvl),
    .rise(s_rise)
  );

  avalon_regs u_regs (
    .clk(clk),
    .reset(reset),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .ctl(ctl.regs)
  );

  // named synchronised signals
  wire tick_rise = s_rise[0];
  wire trig_rise = s_rise[1];
  wire ext_rise = s_rise[2];
  wire jmp_trig = s_lvl[3];
  wire jmp_bin = s_lvl[4];
  wire jmp_ext = s_lvl[5];
  wire jmp_amp = s_lvl[6];

  // status seen by software
  assign ctl.state_code = state;
  assign ctl.modes = {m_amp, m_ext, m_bin, m_trig};
  assign ctl.line = line;

  // counter decodes
  wire vt_end = (vcnt == VT_LAST);
  wire row_done = vt_end & (~m_bin | vrep);
  wire flush_done = (flines == FLUSH_LINES);
  wire pix_end = (pcnt == PIX_LAST);
  wire line_end = pix_end & (col == NUM_COLS - 12'h001);
  wire [11:0] lines_needed = m_bin ? {1'b0, NUM_ROWS[11:1]} : NUM_ROWS;
  wire last_line = ((line + 12'h001) == lines_needed);
  wire [12:0] int_target = int_ticks(ctl.int_sel);
  wire integ_done = m_ext ? ext_rise : (itick >= int_target);
  wire amp_sel = (state == ST_INIT) ? jmp_amp : m_amp;

  // state sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_CLEAR: begin
        next_state = ST_INIT;
      end
      ST_INIT: begin
        if (jmp_trig) begin
          if (trig_rise) begin
            next_state = ST_FLUSH;
          end
        end else if (tick_rise) begin
          next_state = ST_INTEG;
        end
      end
      ST_FLUSH: begin
        if (flush_done && tick_rise) begin
          next_state = ST_INTEG;
        end
      end
      ST_INTEG: begin
        if (integ_done) begin
          next_state = ST_VXFER;
        end
      end
      ST_VXFER: begin
        if (row_done) begin
          next_state = ST_HXFER;
        end
      end
      ST_HXFER: begin
        if (line_end) begin
          next_state = ST_LCHECK;
        end
      end
      ST_LCHECK: begin
        next_state = last_line ? ST_CLEAR : ST_VXFER;
      end
      default: begin
        next_state = ST_CLEAR;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_CLEAR;
    end else begin
      state <= next_state;
    end
  end

  // modes follow the jumpers only while initializing
  always_ff @(posedge clk) begin
    if (reset) begin
      {m_amp, m_ext, m_bin, m_trig} <= 4'h0;
    end else if (state == ST_INIT) begin
      {m_amp, m_ext, m_bin, m_trig} <= {jmp_amp, jmp_ext, jmp_bin, jmp_trig};
    end
  end

  // vertical transfer counter, shared by flush and row transfer
  wire vert_run = (state == ST_VXFER) | ((state == ST_FLUSH) & ~flush_done);
  always_ff @(posedge clk) begin
    if (reset || !vert_run || vt_end) begin
      vcnt <= 8'h00;
    end else begin
      vcnt <= vcnt + 8'h01;
    end
  end

  // second row of a binned pair, and flush line count
  always_ff @(posedge clk) begin
    if (reset || state == ST_CLEAR) begin
      vrep <= 1'b0;
      flines <= 12'h000;
    end else begin
      if (state == ST_VXFER && vt_end) begin
        vrep <= ~vrep;
      end
      if (state == ST_FLUSH && vt_end && !flush_done) begin
        flines <= flines + 12'h001;
      end
    end
  end

  // pixel phase and column counters
  always_ff @(posedge clk) begin
    if (reset || state != ST_HXFER) begin
      pcnt <= 4'h0;
      col <= 12'h000;
    end else begin
      pcnt <= pcnt + 4'h1;
      if (pix_end) begin
        col <= col + 12'h001;
      end
    end
  end

  // line counter, cleared at every frame start
  always_ff @(posedge clk) begin
    if (reset || state == ST_CLEAR) begin
      line <= 12'h000;
    end else if (state == ST_LCHECK) begin
      line <= line + 12'h001;
    end
  end

  // integration ticks; counting starts after the synchronising tick
  always_ff @(posedge clk) begin
    if (reset || state != ST_INTEG) begin
      itick <= 13'h0000;
    end else if (tick_rise) begin
      itick <= itick + 13'h0001;
    end
  end

  // output decode; vertical waveform is hard wired
  wire hx = (state == ST_HXFER);
  wire sense = hx & (~m_bin | col[0]);
  wire next_va = vert_run & (vcnt < V_A_END);
  wire next_vb = vert_run & (vcnt >= V_A_END) & (vcnt < V_B_END);
  wire next_ha = hx & (pcnt < H_SPLIT);
  wire next_hb = hx & (pcnt >= H_SPLIT);
  wire next_rst = sense & in_win(pcnt, RST_ON, RST_OFF);
  wire next_clamp = sense & in_win(pcnt, CLAMP_ON, CLAMP_OFF);
  wire next_samp = sense & in_win(pcnt, SAMP_ON, SAMP_OFF);
  wire next_strobe = sense & in_win(pcnt, STROBE_ON, STROBE_OFF);
  wire next_frame = (state == ST_VXFER) | hx | (state == ST_LCHECK);
  wire next_integ = (next_state == ST_INTEG);
  wire next_amp = amp_sel & next_integ;

  // every output leaves from a flop, one cycle after its decode
  always_ff @(posedge clk) begin
    if (reset) begin
      {vertical_phase_a, vertical_phase_b, horizontal_phase_a, horizontal_phase_b} <= 4'h0;
      {diffusion_reset_clock, clamp_clock, sample_clock} <= 3'h0;
      {grabber_frame_sync, grabber_line_sync, grabber_pixel_strobe} <= 3'h0;
      {integration_active, reduced_amp_supply} <= 2'h0;
    end else begin
      {vertical_phase_a, vertical_phase_b, horizontal_phase_a, horizontal_phase_b} <=
        {next_va, next_vb, next_ha, next_hb};
      {diffusion_reset_clock, clamp_clock, sample_clock} <= {next_rst, next_clamp, next_samp};
      {grabber_frame_sync, grabber_line_sync, grabber_pixel_strobe} <= {next_frame, hx, next_strobe};
      {integration_active, reduced_amp_supply} <= {next_integ, next_amp};
    end
  end

  // checks on the sequencer
  sequence bin_first_row_s;
    state == ST_VXFER && m_bin && vt_end && !vrep;
  endsequence

  sequence clear_entry_s;
    state == ST_CLEAR ##1 state == ST_INIT;
  endsequence

  amp_normal_a: assert property (@(posedge clk) disable iff (reset)
    !amp_sel |=> !reduced_amp_supply) else $error("reduced supply with jumper low");

  amp_follow_a: assert property (@(posedge clk) disable iff (reset)
    m_amp && state != ST_INIT |-> reduced_amp_supply == integration_active)
    else $error("supply select not following integration");

  reset_state_a: assert property (@(posedge clk)
    reset |=> state == ST_CLEAR && line == 12'h000 && itick == 13'h0000 && !integration_active)
    else $error("reset did not clear sequencer");

  frame_start_a: assert property (@(posedge clk) disable iff (reset)
    clear_entry_s |-> vcnt == 8'h00 && line == 12'h000 && flines == 12'h000)
    else $error("counters not cleared at frame start");

  init_hold_a: assert property (@(posedge clk) disable iff (reset)
    state == ST_INIT && !jmp_trig && !tick_rise |=> state == ST_INIT)
    else $error("left initialize without tick");

  flush_mode_a: assert property (@(posedge clk) disable iff (reset)
    state == ST_FLUSH |-> m_trig) else $error("flush in continuous mode");

  flush_wait_a: assert property (@(posedge clk) disable iff (reset)
    state == ST_FLUSH && flush_done |=> !vertical_phase_a && !vertical_phase_b)
    else $error("vertical clocks running after flush");

  integ_high_a: assert property (@(posedge clk) disable iff (reset)
    state == ST_INTEG |-> integration_active) else $error("integration output low in integrate");

  ext_end_a: assert property (@(posedge clk) disable iff (reset)
    state == ST_INTEG && m_ext && ext_rise |=> state == ST_VXFER && !integration_active)
    else $error("external end ignored");

  int_end_a: assert property (@(posedge clk) disable iff (reset)
    state == ST_INTEG && !m_ext && itick < int_target |=> state == ST_INTEG)
    else $error("internal integration ended early");

  vert_pulse_a: assert property (@(posedge clk) disable iff (reset)
    state == ST_VXFER && vcnt == 8'h00 |=> vertical_phase_a && !vertical_phase_b)
    else $error("vertical phase a missing at row start");

  bin_rows_a: assert property (@(posedge clk) disable iff (reset)
    bin_first_row_s |=> state == ST_VXFER && vcnt == 8'h00) else $error("binned row pair cut short");

  bin_gate_a: assert property (@(posedge clk) disable iff (reset)
    hx && m_bin && !col[0] |=> !grabber_pixel_strobe && !diffusion_reset_clock && !clamp_clock)
    else $error("binned pixel not gated");

  line_inc_a: assert property (@(posedge clk) disable iff (reset)
    state == ST_LCHECK |=> line == $past(line) + 12'h001) else $error("line counter not advanced");
endmodule

// [src/edge_sync.sv]
`timescale 1ns/1ps
module edge_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // asynchronous inputs and their synchronised forms
  input wire logic [W-1:0] d,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // two stages against metastability, a third only for edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign lvl = s2;
  assign rise = s2 & ~s3;
endmodule
